// [src/tcr_pkg.sv]
// Shared constants for the transmit control register bank
package tcr_pkg;
  localparam int FRAME_BITS = 56;
  localparam int CNT_W = 6;
  localparam int CS_BITS = 48;
  localparam logic [7:0] DEV_ADDR_CTRL = 8'he8;
  localparam logic [7:0] DEV_ADDR_CS = 8'he9;
  localparam logic [3:0] CMD_SYS_GPIO = 4'ha;
  localparam logic [3:0] CMD_AUDIO = 4'hb;
  localparam logic [5:0] CTRL_FRAME_LEN = 6'h10;
  // Header field positions
  localparam int POS_CHIP_LSB = 0;
  localparam int POS_HDR_ZERO_LSB = 2;
  localparam int POS_CMD_LSB = 4;
  localparam int POS_LEN_LSB = 4;
  localparam int POS_PAYLOAD = 8;
  localparam logic [2:0] LEN_CODE_MAX = 3'h5;
  // System and general output register fields
  localparam int POS_USER_SEL = 8;
  localparam int POS_VALID_SEL = 9;
  localparam int POS_VFLAG = 10;
  localparam int POS_GPO_LSB = 12;
  // Audio input register fields
  localparam int POS_FORMAT = 8;
  localparam int POS_POLARITY = 9;
  localparam int POS_SOURCE = 10;
  localparam int POS_MUTE = 11;
  localparam int POS_MODE_LSB = 12;
  localparam logic [1:0] MODE_RESERVED = 2'h3;
  // Values after reset
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [3:0] GPO_RESET = 4'h0;
  localparam logic [47:0] CS_RESET = 48'h0;
  typedef enum logic [1:0] {
    TCR_ST_IDLE = 2'b00,
    TCR_ST_DECODE = 2'b01,
    TCR_ST_PENDING = 2'b11
  } tcr_state_t;
endpackage

// [src/tcr_link_rx.sv]
// Serial control link receiver running on the host serial clock
`timescale 1ns/1ps
module tcr_link_rx (
  input wire logic serial_clk,
  input wire logic sys_rst,
  input wire logic chip_enable,
  input wire logic serial_data_in,
  output logic [7:0] dev_addr,
  output logic [tcr_pkg::FRAME_BITS-1:0] frame_data,
  output logic [tcr_pkg::CNT_W-1:0] frame_count
);
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic [tcr_pkg::FRAME_BITS-1:0] data_reg;
  logic [tcr_pkg::FRAME_BITS-1:0] data_next;
  logic [tcr_pkg::CNT_W-1:0] cnt_reg;
  logic [tcr_pkg::CNT_W-1:0] cnt_next;

  // Address phase with enable low, data phase with enable high, both LSB first
  always_comb begin
    addr_next = addr_reg;
    data_next = data_reg;
    cnt_next = cnt_reg;
    if (!chip_enable) begin
      addr_next = {serial_data_in, addr_reg[7:1]};
      cnt_next = '0;
    end else if (cnt_reg < tcr_pkg::CNT_W'(tcr_pkg::FRAME_BITS)) begin
      data_next[cnt_reg] = serial_data_in;
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg <= 8'h00;
      data_reg <= '0;
      cnt_reg <= '0;
    end else begin
      addr_reg <= addr_next;
      data_reg <= data_next;
      cnt_reg <= cnt_next;
    end
  end

  assign dev_addr = addr_reg;
  assign frame_data = data_reg;
  assign frame_count = cnt_reg;
endmodule // tcr_link_rx

// [src/tcr_tx_control_regs.sv]
// Transmit side control registers behind the four-wire serial control link
// Functional notes
// - System/output register: 0xE8, command 1010
// - Audio register: 0xE8, command 1011, top zero
// - User pin select: receiver six or user
// - Validity pin select: receiver five or validity
// - Validity control bit value sent in stream
// - Four level bits drive general outputs
// - Format bit: I2S or left-justified
// - Word clock polarity picks left/right sense
// - Source bit picks primary or secondary input
// - Mute holds modulated output low
// - Channel mode: stereo, left, right; 11 reserved
// - Channel status written at 0xE9
// - Length code gives bytes minus one
// - New status applied at next block start
// - Serial bit eight plus k loads bit k
`timescale 1ns/1ps
module tcr_tx_control_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic serial_clk,
  input wire logic chip_enable,
  input wire logic serial_data_in,
  input wire logic chip_addr_high,
  input wire logic chip_addr_low,
  input wire logic general_port_dir_pin,
  input wire logic shared_pin_six,
  input wire logic shared_pin_five,
  input wire logic tx_serial_in,
  input wire logic secondary_serial_in,
  input wire logic tx_word_clock,
  input wire logic encoded_stream,
  input wire logic block_start,
  output logic receive_input_six,
  output logic receive_input_five,
  output logic user_bit_input,
  output logic validity_input,
  output logic tx_validity_bit,
  output logic [3:0] general_port_pin_out,
  output logic [3:0] general_port_pin_oe,
  output logic tx_serial_format,
  output logic tx_left_channel,
  output logic tx_audio_data,
  output logic modulated_output,
  output logic [1:0] tx_channel_mode,
  output logic user_pin_select,
  output logic validity_pin_select,
  output logic validity_flag_value,
  output logic tx_word_clock_polarity,
  output logic tx_source_select,
  output logic tx_output_mute,
  output logic [tcr_pkg::CS_BITS-1:0] channel_status
);
  localparam int SYNC_W = 9;
  // Direction bit resets high so general outputs stay off until the pin is seen
  localparam logic [SYNC_W-1:0] SYNC_RESET = 9'h020;

  function automatic logic [tcr_pkg::CNT_W-1:0] cs_len_bits(input logic [2:0] code);
    cs_len_bits = tcr_pkg::CNT_W'({code, 3'b000}) + tcr_pkg::CNT_W'(8);
  endfunction

  logic [7:0] link_addr;
  logic [tcr_pkg::FRAME_BITS-1:0] link_data;
  logic [tcr_pkg::CNT_W-1:0] link_count;

  tcr_link_rx u_link (
    .serial_clk(serial_clk),
    .sys_rst(sys_rst),
    .chip_enable(chip_enable),
    .serial_data_in(serial_data_in),
    .dev_addr(link_addr),
    .frame_data(link_data),
    .frame_count(link_count)
  );

  // Two-stage synchronisers for the pin levels other than serial data, encoded stream and block start
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] pins_raw;
  logic ce_del_reg;
  logic ce_s, cah_s, cal_s, dir_s, pin6_s, pin5_s;
  logic tdata_s, sdata_s, wclk_s;

  assign pins_raw = {chip_enable, chip_addr_high, chip_addr_low, general_port_dir_pin,
                     shared_pin_six, shared_pin_five, tx_serial_in, secondary_serial_in,
                     tx_word_clock};
  assign {ce_s, cah_s, cal_s, dir_s, pin6_s, pin5_s, tdata_s, sdata_s, wclk_s} =
    sync2_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
      ce_del_reg <= 1'b0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      ce_del_reg <= ce_s;
    end
  end

  // Frame end: link clock is idle, so the captured frame is stable
  logic frame_end;
  assign frame_end = ce_del_reg & ~ce_s;

  // Control and status state
  tcr_pkg::tcr_state_t state_reg;
  tcr_pkg::tcr_state_t state_next;
  logic [7:0] cap_addr_reg;
  logic [7:0] cap_addr_next;
  logic [tcr_pkg::FRAME_BITS-1:0] cap_data_reg;
  logic [tcr_pkg::FRAME_BITS-1:0] cap_data_next;
  logic [tcr_pkg::CNT_W-1:0] cap_cnt_reg;
  logic [tcr_pkg::CNT_W-1:0] cap_cnt_next;
  logic usel_reg, usel_next;
  logic vsel_reg, vsel_next;
  logic vflag_reg, vflag_next;
  logic [3:0] gpo_reg;
  logic [3:0] gpo_next;
  logic fmt_reg, fmt_next;
  logic pol_reg, pol_next;
  logic src_reg, src_next;
  logic mute_reg, mute_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic [tcr_pkg::CS_BITS-1:0] cs_stage_reg;
  logic [tcr_pkg::CS_BITS-1:0] cs_stage_next;
  logic [tcr_pkg::CS_BITS-1:0] cs_active_reg;
  logic [tcr_pkg::CS_BITS-1:0] cs_active_next;
  logic from_pend_reg, from_pend_next;

  logic chip_match;
  logic hdr_zero;
  logic [3:0] cmd;
  logic [2:0] len_code;
  logic [tcr_pkg::CNT_W-1:0] len_bits;
  logic ctrl_ok;
  logic cs_ok;

  assign chip_match = cap_data_reg[tcr_pkg::POS_CHIP_LSB +: 2] == {cah_s, cal_s};
  assign hdr_zero = cap_data_reg[tcr_pkg::POS_HDR_ZERO_LSB +: 2] == 2'b00;
  assign cmd = cap_data_reg[tcr_pkg::POS_CMD_LSB +: 4];
  assign len_code = cap_data_reg[tcr_pkg::POS_LEN_LSB +: 3];
  assign len_bits = cs_len_bits(len_code);
  assign ctrl_ok = (cap_addr_reg == tcr_pkg::DEV_ADDR_CTRL) && chip_match && hdr_zero
                   && (cap_cnt_reg >= tcr_pkg::CTRL_FRAME_LEN);
  assign cs_ok = (cap_addr_reg == tcr_pkg::DEV_ADDR_CS) && chip_match
                 && (len_code <= tcr_pkg::LEN_CODE_MAX)
                 && (cap_cnt_reg >= len_bits + tcr_pkg::CNT_W'(tcr_pkg::POS_PAYLOAD));

  always_comb begin
    state_next = state_reg;
    cap_addr_next = cap_addr_reg;
    cap_data_next = cap_data_reg;
    cap_cnt_next = cap_cnt_reg;
    usel_next = usel_reg;
    vsel_next = vsel_reg;
    vflag_next = vflag_reg;
    gpo_next = gpo_reg;
    fmt_next = fmt_reg;
    pol_next = pol_reg;
    src_next = src_reg;
    mute_next = mute_reg;
    mode_next = mode_reg;
    cs_stage_next = cs_stage_reg;
    cs_active_next = cs_active_reg;
    from_pend_next = (state_reg == tcr_pkg::TCR_ST_PENDING);
    if (frame_end) begin
      cap_addr_next = link_addr;
      cap_data_next = link_data;
      cap_cnt_next = link_count;
    end
    case (state_reg)
      tcr_pkg::TCR_ST_IDLE: begin
        if (frame_end) begin
          state_next = tcr_pkg::TCR_ST_DECODE;
        end
      end
      tcr_pkg::TCR_ST_DECODE: begin
        // A control frame must not drop status still waiting for a block start
        state_next = from_pend_reg ? tcr_pkg::TCR_ST_PENDING : tcr_pkg::TCR_ST_IDLE;
        if (ctrl_ok && cmd == tcr_pkg::CMD_SYS_GPIO) begin
          usel_next = cap_data_reg[tcr_pkg::POS_USER_SEL];
          vsel_next = cap_data_reg[tcr_pkg::POS_VALID_SEL];
          vflag_next = cap_data_reg[tcr_pkg::POS_VFLAG];
          gpo_next = cap_data_reg[tcr_pkg::POS_GPO_LSB +: 4];
        end else if (ctrl_ok && cmd == tcr_pkg::CMD_AUDIO) begin
          fmt_next = cap_data_reg[tcr_pkg::POS_FORMAT];
          pol_next = cap_data_reg[tcr_pkg::POS_POLARITY];
          src_next = cap_data_reg[tcr_pkg::POS_SOURCE];
          mute_next = cap_data_reg[tcr_pkg::POS_MUTE];
          if (cap_data_reg[tcr_pkg::POS_MODE_LSB +: 2] != tcr_pkg::MODE_RESERVED) begin
            mode_next = cap_data_reg[tcr_pkg::POS_MODE_LSB +: 2];
          end
        end else if (cs_ok) begin
          for (int k = 0; k < tcr_pkg::CS_BITS; k++) begin
            if (k < int'(len_bits)) begin
              cs_stage_next[k] = cap_data_reg[tcr_pkg::POS_PAYLOAD + k];
            end
          end
          state_next = tcr_pkg::TCR_ST_PENDING;
        end
      end
      tcr_pkg::TCR_ST_PENDING: begin
        if (frame_end) begin
          state_next = tcr_pkg::TCR_ST_DECODE;
        end
        if (block_start) begin
          cs_active_next = cs_stage_reg;
          if (!frame_end) begin
            state_next = tcr_pkg::TCR_ST_IDLE;
          end
        end
      end
      default: begin
        state_next = tcr_pkg::TCR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= tcr_pkg::TCR_ST_IDLE;
      cap_addr_reg <= 8'h00;
      cap_data_reg <= '0;
      cap_cnt_reg <= '0;
      usel_reg <= 1'b0;
      vsel_reg <= 1'b0;
      vflag_reg <= 1'b0;
      gpo_reg <= tcr_pkg::GPO_RESET;
      fmt_reg <= 1'b0;
      pol_reg <= 1'b0;
      src_reg <= 1'b0;
      mute_reg <= 1'b0;
      mode_reg <= tcr_pkg::MODE_RESET;
      cs_stage_reg <= tcr_pkg::CS_RESET;
      cs_active_reg <= tcr_pkg::CS_RESET;
      from_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cap_addr_reg <= cap_addr_next;
      cap_data_reg <= cap_data_next;
      cap_cnt_reg <= cap_cnt_next;
      usel_reg <= usel_next;
      vsel_reg <= vsel_next;
      vflag_reg <= vflag_next;
      gpo_reg <= gpo_next;
      fmt_reg <= fmt_next;
      pol_reg <= pol_next;
      src_reg <= src_next;
      mute_reg <= mute_next;
      mode_reg <= mode_next;
      cs_stage_reg <= cs_stage_next;
      cs_active_reg <= cs_active_next;
      from_pend_reg <= from_pend_next;
    end
  end

  // Datapath steered by the registers
  logic rx6_next, rx5_next, ui_next, vi_next, vbit_next;
  logic left_next, audio_next, txo_next;
  logic [3:0] gpo_out_next;
  logic [3:0] gpo_oe_next;
  logic rx6_reg, rx5_reg, ui_reg, vi_reg, vbit_reg;
  logic left_reg, audio_reg, txo_reg;
  logic [3:0] gpo_out_reg;
  logic [3:0] gpo_oe_reg;

  always_comb begin
    rx6_next = usel_reg ? 1'b0 : pin6_s;
    ui_next = usel_reg ? pin6_s : 1'b0;
    rx5_next = vsel_reg ? 1'b0 : pin5_s;
    vi_next = vsel_reg ? pin5_s : 1'b0;
    vbit_next = vsel_reg ? pin5_s : vflag_reg;
    gpo_oe_next = dir_s ? 4'h0 : 4'hf;
    gpo_out_next = gpo_reg;
    left_next = wclk_s ^ ~pol_reg;
    audio_next = src_reg ? sdata_s : tdata_s;
    txo_next = mute_reg ? 1'b0 : encoded_stream;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx6_reg <= 1'b0;
      rx5_reg <= 1'b0;
      ui_reg <= 1'b0;
      vi_reg <= 1'b0;
      vbit_reg <= 1'b0;
      gpo_out_reg <= tcr_pkg::GPO_RESET;
      gpo_oe_reg <= 4'h0;
      left_reg <= 1'b0;
      audio_reg <= 1'b0;
      txo_reg <= 1'b0;
    end else begin
      rx6_reg <= rx6_next;
      rx5_reg <= rx5_next;
      ui_reg <= ui_next;
      vi_reg <= vi_next;
      vbit_reg <= vbit_next;
      gpo_out_reg <= gpo_out_next;
      gpo_oe_reg <= gpo_oe_next;
      left_reg <= left_next;
      audio_reg <= audio_next;
      txo_reg <= txo_next;
    end
  end

  assign receive_input_six = rx6_reg;
  assign receive_input_five = rx5_reg;
  assign user_bit_input = ui_reg;
  assign validity_input = vi_reg;
  assign tx_validity_bit = vbit_reg;
  assign general_port_pin_out = gpo_out_reg;
  assign general_port_pin_oe = gpo_oe_reg;
  assign tx_serial_format = fmt_reg;
  assign tx_left_channel = left_reg;
  assign tx_audio_data = audio_reg;
  assign modulated_output = txo_reg;
  assign tx_channel_mode = mode_reg;
  assign user_pin_select = usel_reg;
  assign validity_pin_select = vsel_reg;
  assign validity_flag_value = vflag_reg;
  assign tx_word_clock_polarity = pol_reg;
  assign tx_source_select = src_reg;
  assign tx_output_mute = mute_reg;
  assign channel_status = cs_active_reg;
endmodule // tcr_tx_control_regs

// [sim/tcr_tx_control_regs_sva.sv]
// Checker for the transmit control register bank
`timescale 1ns/1ps
module tcr_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic chip_enable,
  input wire logic general_port_dir_pin,
  input wire logic tx_serial_in,
  input wire logic secondary_serial_in,
  input wire logic tx_word_clock,
  input wire logic encoded_stream,
  input wire logic block_start,
  input wire logic user_bit_input,
  input wire logic tx_validity_bit,
  input wire logic [3:0] general_port_pin_oe,
  input wire logic tx_serial_format,
  input wire logic tx_left_channel,
  input wire logic tx_audio_data,
  input wire logic modulated_output,
  input wire logic [1:0] tx_channel_mode,
  input wire logic user_pin_select,
  input wire logic validity_pin_select,
  input wire logic validity_flag_value,
  input wire logic tx_word_clock_polarity,
  input wire logic tx_source_select,
  input wire logic tx_output_mute,
  input wire logic [tcr_pkg::CS_BITS-1:0] channel_status
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_MUTE_LOW: assert property (tx_output_mute |=> !modulated_output)
    else $error("modulated output not held low");
  AST_MUTE_PASS: assert property (
    !tx_output_mute |=> modulated_output == $past(encoded_stream))
    else $error("modulated output does not follow stream");
  AST_MODE_LEGAL: assert property (tx_channel_mode != tcr_pkg::MODE_RESERVED)
    else $error("reserved channel mode taken");
  AST_OE_OFF: assert property (general_port_dir_pin [*5] |-> general_port_pin_oe == 4'h0)
    else $error("general outputs enabled with direction high");
  AST_OE_ON: assert property ((!general_port_dir_pin) [*5] |-> general_port_pin_oe == 4'hf)
    else $error("general outputs not enabled");
  AST_USER_GATE: assert property ((!user_pin_select) [*3] |-> !user_bit_input)
    else $error("user input routed while unselected");
  AST_VFLAG: assert property (
    (!validity_pin_select && $stable(validity_flag_value)) [*3]
    |-> tx_validity_bit == validity_flag_value) else $error("validity bit wrong");
  AST_CS_AT_BLOCK: assert property ($changed(channel_status) |-> $past(block_start))
    else $error("channel status changed outside block start");
  AST_CTRL_AFTER_CE: assert property (
    $changed({tx_channel_mode, tx_output_mute, tx_source_select, tx_word_clock_polarity,
      tx_serial_format, user_pin_select, validity_pin_select, validity_flag_value})
    |-> !chip_enable && $past(chip_enable, 4) == 1'b0) else $error("early register update");
  AST_WCLK: assert property (
    ($stable(tx_word_clock) && $stable(tx_word_clock_polarity)) [*4]
    |-> tx_left_channel == (tx_word_clock ~^ tx_word_clock_polarity))
    else $error("left channel sense wrong");
  AST_SOURCE: assert property (
    ($stable(tx_serial_in) && $stable(secondary_serial_in) && $stable(tx_source_select)) [*4]
    |-> tx_audio_data == (tx_source_select ? secondary_serial_in : tx_serial_in))
    else $error("audio source wrong");
endmodule // tcr_chk

bind tcr_tx_control_regs tcr_chk tcr_chk_inst (.core_clk, .sys_rst, .chip_enable,
  .general_port_dir_pin, .tx_serial_in, .secondary_serial_in, .tx_word_clock,
  .encoded_stream, .block_start, .user_bit_input, .tx_validity_bit, .general_port_pin_oe,
  .tx_serial_format, .tx_left_channel, .tx_audio_data, .modulated_output, .tx_channel_mode,
  .user_pin_select, .validity_pin_select, .validity_flag_value, .tx_word_clock_polarity,
  .tx_source_select, .tx_output_mute, .channel_status);

// [sim/tcr_host_model.sv]
// Host side model of the four-wire serial control link
`timescale 1ns/1ps
module tcr_host_model (
  output logic serial_clk,
  output logic chip_enable,
  output logic serial_data_in
);
  initial begin
    serial_clk = 1'b0;
    chip_enable = 1'b0;
    serial_data_in = 1'b0;
  end
  // Link clock runs only inside a frame, LSB first
  task automatic frame(input logic [7:0] addr, input logic [55:0] data, input int nbits);
    for (int i = 0; i < 8; i++) begin
      serial_data_in = addr[i];
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
    end
    chip_enable = 1'b1;
    for (int i = 0; i < nbits; i++) begin
      serial_data_in = data[i];
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
    end
    #40 chip_enable = 1'b0;
    serial_data_in = ~serial_data_in;
  endtask
endmodule // tcr_host_model

// [sim/tb.sv]
// Self-checking bench for the transmit control register bank
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_addr_high = 1'b1;
  logic chip_addr_low = 1'b0;
  logic general_port_dir_pin = 1'b0;
  logic shared_pin_six = 1'b0, shared_pin_five = 1'b0, tx_serial_in = 1'b0;
  logic secondary_serial_in = 1'b0, tx_word_clock = 1'b0;
  logic encoded_stream = 1'b0, block_start = 1'b0;
  logic serial_clk, chip_enable, serial_data_in;
  logic receive_input_six, receive_input_five, user_bit_input, validity_input;
  logic tx_validity_bit, tx_serial_format, tx_left_channel, tx_audio_data;
  logic modulated_output, user_pin_select, validity_pin_select, validity_flag_value;
  logic tx_word_clock_polarity, tx_source_select, tx_output_mute;
  logic [3:0] general_port_pin_out, general_port_pin_oe;
  logic [1:0] tx_channel_mode;
  logic [tcr_pkg::CS_BITS-1:0] channel_status, exp, pat, mask;
  logic [7:0] sys_q;
  logic [5:0] aud_q;
  logic [4:0] route_q;
  logic [2:0] dp_q;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  assign sys_q = {general_port_pin_out, 1'b0, validity_flag_value, validity_pin_select,
    user_pin_select};
  assign aud_q = {tx_channel_mode, tx_output_mute, tx_source_select, tx_word_clock_polarity,
    tx_serial_format};
  assign route_q = {receive_input_six, user_bit_input, receive_input_five, validity_input,
    tx_validity_bit};
  assign dp_q = {tx_left_channel, tx_audio_data, modulated_output};
  tcr_host_model tcr_host_model_inst (.serial_clk, .chip_enable, .serial_data_in);
  tcr_tx_control_regs tcr_tx_control_regs_inst (.core_clk, .sys_rst, .serial_clk,
    .chip_enable, .serial_data_in, .chip_addr_high, .chip_addr_low, .general_port_dir_pin,
    .shared_pin_six, .shared_pin_five, .tx_serial_in, .secondary_serial_in, .tx_word_clock,
    .encoded_stream, .block_start, .receive_input_six, .receive_input_five, .user_bit_input,
    .validity_input, .tx_validity_bit, .general_port_pin_out, .general_port_pin_oe,
    .tx_serial_format, .tx_left_channel, .tx_audio_data, .modulated_output, .tx_channel_mode,
    .user_pin_select, .validity_pin_select, .validity_flag_value, .tx_word_clock_polarity,
    .tx_source_select, .tx_output_mute, .channel_status);
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [47:0] e, input logic [47:0] got);
    cmp_count++;
    if (got !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic send(input logic [7:0] addr, input logic [55:0] data, input int nbits);
    tcr_host_model_inst.frame(addr, data, nbits);
    tick(20);
  endtask
  task automatic wr_ctrl(input logic [3:0] cmd, input logic [1:0] chip, input logic [7:0] v);
    send(tcr_pkg::DEV_ADDR_CTRL, {40'h0, v, cmd, 2'b00, chip}, 16);
  endtask
  task automatic wr_cs(input logic [2:0] code, input logic [47:0] bits);
    send(tcr_pkg::DEV_ADDR_CS, {bits, 1'b0, code, 2'b00, 2'b10}, 56);
  endtask
  task automatic pulse();
    @(posedge core_clk) block_start <= 1'b1;
    @(posedge core_clk) block_start <= 1'b0;
    tick(2);
  endtask
  task automatic reset_dut();
    @(posedge core_clk) sys_rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    tick(4);
    chk("sys", 8'h00, sys_q);
    chk("aud", 6'h00, aud_q);
    chk("cs", 48'h0, channel_status);
  endtask
  initial begin
    reset_dut();
    wr_ctrl(tcr_pkg::CMD_SYS_GPIO, 2'b10, 8'h55);
    chk("sys", 8'h55, sys_q);
    // Wrong chip, header zeros, short frame, device and command are all dropped
    wr_ctrl(tcr_pkg::CMD_SYS_GPIO, 2'b01, 8'h0a);
    send(tcr_pkg::DEV_ADDR_CTRL, {40'h0, 8'h0a, 8'ha6}, 16);
    send(tcr_pkg::DEV_ADDR_CTRL, {40'h0, 8'h0a, 8'ha2}, 15);
    send(8'he7, {40'h0, 8'h0a, 8'ha2}, 16);
    wr_ctrl(4'hc, 2'b10, 8'h0a);
    chk("sys", 8'h55, sys_q);
    @(posedge core_clk) shared_pin_six <= 1'b1;
    @(posedge core_clk) shared_pin_five <= 1'b1;
    tick(6);
    chk("route", 5'b01101, route_q);
    wr_ctrl(tcr_pkg::CMD_SYS_GPIO, 2'b10, 8'h02);
    chk("route", 5'b10011, route_q);
    chk("oe", 4'hf, general_port_pin_oe);
    @(posedge core_clk) general_port_dir_pin <= 1'b1;
    @(posedge core_clk) encoded_stream <= 1'b1;
    @(posedge core_clk) tx_word_clock <= 1'b1;
    @(posedge core_clk) secondary_serial_in <= 1'b1;
    tick(6);
    chk("oe", 4'h0, general_port_pin_oe);
    chk("dp", 3'b001, dp_q);
    wr_ctrl(tcr_pkg::CMD_AUDIO, 2'b10, 8'h1f);
    chk("aud", 6'h1f, aud_q);
    chk("dp", 3'b110, dp_q);
    wr_ctrl(tcr_pkg::CMD_AUDIO, 2'b10, 8'h30);
    chk("aud", 6'h10, aud_q);
    wr_ctrl(tcr_pkg::CMD_AUDIO, 2'b10, 8'h20);
    chk("aud", 6'h20, aud_q);
    exp = 48'h123456789abc;
    wr_cs(3'h5, exp);
    chk("cs", 48'h0, channel_status);
    pulse();
    chk("cs", exp, channel_status);
    for (int c = 0; c < 6; c++) begin
      pat = {6{8'(8'ha0 + c)}};
      mask = (48'h1 << (8 * (c + 1))) - 48'h1;
      exp = (exp & ~mask) | (pat & mask);
      wr_cs(3'(c), pat);
      // A control write while status waits must not lose it
      if (c == 2) wr_ctrl(tcr_pkg::CMD_AUDIO, 2'b10, 8'h20);
      pulse();
      chk("cs", exp, channel_status);
    end
    wr_cs(3'h6, 48'h0);
    send(tcr_pkg::DEV_ADDR_CS, {48'hffffffffffff, 8'h02}, 15);
    pulse();
    chk("cs", exp, channel_status);
    reset_dut();
    summarize();
  end
endmodule // tb
